// [design/pss_bank.sv]
// Status summary, event latch and interrupt-enable bank on AXI4-Lite.
// Overview of operation
// - Bits 15:14 report resolved speed code.
// - Bit 13 shows full duplex, resets zero.
// - Bit 12 latches page received, read clears.
// - Bit 11 set when negotiation done/off.
// - Bit 10 shows live link state.
// - Bit 9 shows crossover of pairs three/four.
// - Bit 8 shows crossover of pairs one/two.
// - Bit 7 shows gigabit masked by optimization.
// - Bit 6 shows sleep mode.
// - Bits 5:2 show reversed polarity D..A.
// - Bit 1 shows ten-meg polarity, resets one.
// - Bit 0 mirrors jabber, read never clears.
// - Interrupt only for enabled, occurring events.
// - Enable bits 15:10 read/write, reset zero.
// - Enable bits 8,6,5,4 read/write, reset zero.
// - Enable bits 3:0 read/write, reset zero.
// - Events except reserved bits 9 and 7 latch regardless of enable; read clears.
// - Config bit 13 selects pin polarity.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/100ps
`include "pss_regs.svh"

module pss_bank
  import pss_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire pss_live_t live_i,
  input wire logic page_rx_i,
  input wire logic [15:0] event_pulse_i,
  output logic irq_o
);

  // Reset synchroniser stages; only the second stage is used by logic.
  logic rst_meta_n;
  logic rst_n;
  // Current and next state of the whole bank.
  pss_state_t st;
  pss_state_t next_st;
  // Index of the register addressed by the pending write and the read.
  logic [5:0] wr_idx;
  logic [5:0] rd_idx;
  // High while an address has a bit set above bit 7.
  logic wr_hi_bad;
  logic rd_hi_bad;
  // Byte mask expanded from the two low write strobes.
  logic [15:0] wr_mask;
  // Read data chosen for the accepted read address.
  logic [31:0] rd_word;
  logic rd_ok;
  // Enabled pending events.
  logic irq_active;

  // The release of reset is retimed so that all flops leave reset together.
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // Address decode helpers; the two low address bits are ignored.
  assign wr_idx = st.aw_addr[7:2];
  assign rd_idx = s_axi_araddr_i[7:2];
  // Wider buses must not alias a stray high address onto a live register.
  assign wr_hi_bad = (ADDR_W > 8) ? (|(s_axi_awaddr_i >> 8)) : 1'b0;
  assign rd_hi_bad = (ADDR_W > 8) ? (|(s_axi_araddr_i >> 8)) : 1'b0;
  assign wr_mask = {{8{st.w_strb[1]}}, {8{st.w_strb[0]}}};
  assign irq_active = |(st.events & st.enable);

  // Read multiplexer; unmapped indexes answer zero with an error.
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_ok = !rd_hi_bad;
    case (rd_idx)
      `PSS_IDX_STATUS:
      begin
        rd_word[15:0] = st.status;
        rd_word[`PSS_STS_PAGE] = st.page;
      end
      `PSS_IDX_ENABLE:
      begin
        rd_word[15:0] = st.enable;
      end
      `PSS_IDX_EVENT:
      begin
        rd_word[15:0] = st.events;
      end
      `PSS_IDX_CONFIG:
      begin
        rd_word[`PSS_CFG_POL] = st.irq_low;
      end
      default:
      begin
        rd_ok = 1'b0;
      end
    endcase
  end

  // Next-state logic for the bus slave, the latches and the pin.
  always_comb
  begin
    next_st = st;
    // Live status is retimed once so each read sees a stable word.
    next_st.status[`PSS_STS_RATE_HI:`PSS_STS_RATE_LO] =
      live_i.resolved_rate;
    next_st.status[`PSS_STS_DUPLEX] = live_i.full_duplex;
    next_st.status[`PSS_STS_PAGE] = 1'b0;
    next_st.status[`PSS_STS_RESOLVED] = live_i.neg_resolved;
    next_st.status[`PSS_STS_LINK] = live_i.link_up;
    next_st.status[`PSS_STS_X34] = live_i.crossover_pairs_34;
    next_st.status[`PSS_STS_X12] = live_i.crossover_pairs_12;
    next_st.status[`PSS_STS_GIGMASK] = live_i.gigabit_mask_active;
    next_st.status[`PSS_STS_DORMANT] = live_i.dormant;
    next_st.status[`PSS_STS_POL_HI:`PSS_STS_POL_LO] =
      live_i.channel_polarity_reversed;
    next_st.status[`PSS_STS_POL10] = live_i.pol10_correct;
    // Jabber is a copy only; reading here never clears the source.
    next_st.status[`PSS_STS_JABBER] = live_i.jabber;

    // Write address and data are captured independently, in any order.
    if (s_axi_awvalid_i && st.awready)
    begin
      next_st.aw_held = 1'b1;
      // An address beyond the map is parked on index zero, which errors.
      next_st.aw_addr = wr_hi_bad ? 8'h00 : s_axi_awaddr_i[7:0];
    end
    if (s_axi_wvalid_i && st.wready)
    begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata_i;
      next_st.w_strb = s_axi_wstrb_i;
    end
    // A finished response frees the channel.
    if (st.bvalid && s_axi_bready_i)
    begin
      next_st.bvalid = 1'b0;
    end
    // Both halves present: perform the write and answer.
    if (st.aw_held && st.w_held && !st.bvalid)
    begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `PSS_RESP_OKAY;
      case (wr_idx)
        `PSS_IDX_ENABLE:
        begin
          // Reserved enable bits never take a write.
          next_st.enable = (st.enable & ~(wr_mask & `PSS_EN_WMASK)) |
            (st.w_data[15:0] & wr_mask & `PSS_EN_WMASK);
        end
        `PSS_IDX_CONFIG:
        begin
          if (st.w_strb[1])
          begin
            next_st.irq_low = st.w_data[`PSS_CFG_POL];
          end
        end
        `PSS_IDX_STATUS, `PSS_IDX_EVENT:
        begin
          // Read-only registers accept and drop the write.
          next_st.bresp = `PSS_RESP_OKAY;
        end
        default:
        begin
          // Unmapped or out-of-range writes are refused with an error.
          next_st.bresp = `PSS_RESP_SLVERR;
        end
      endcase
    end
    next_st.awready = !next_st.aw_held;
    next_st.wready = !next_st.w_held;

    // Page and event latches: a new set wins over a clearing read.
    next_st.page = st.page;
    next_st.events = st.events;
    // The read answer stands until the host takes it.
    if (st.rvalid && s_axi_rready_i)
    begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && st.arready)
    begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_word;
      next_st.rresp = rd_ok ? `PSS_RESP_OKAY : `PSS_RESP_SLVERR;
      if (rd_ok && rd_idx == `PSS_IDX_STATUS)
      begin
        next_st.page = 1'b0;
      end
      if (rd_ok && rd_idx == `PSS_IDX_EVENT)
      begin
        next_st.events = `PSS_EVT_RESET;
      end
    end
    next_st.page = next_st.page | page_rx_i;
    // Every event except reserved bits 9 and 7 latches whatever its enable says.
    next_st.events = next_st.events | (event_pulse_i & `PSS_EN_WMASK);
    next_st.arready = !next_st.rvalid;

    // The pin follows enabled pending events in the chosen polarity.
    next_st.irq_pin = irq_active ^ st.irq_low;
  end

  // State register; reset loads constants only.
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.status <= `PSS_STS_RESET;
      st.enable <= `PSS_EN_RESET;
      st.events <= `PSS_EVT_RESET;
      st.irq_low <= `PSS_CFG_POL_RESET;
      st.irq_pin <= `PSS_CFG_POL_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Every output comes straight from the state register.
  assign s_axi_awready_o = st.awready;
  assign s_axi_wready_o = st.wready;
  assign s_axi_bvalid_o = st.bvalid;
  assign s_axi_bresp_o = st.bresp;
  assign s_axi_arready_o = st.arready;
  assign s_axi_rvalid_o = st.rvalid;
  assign s_axi_rdata_o = st.rdata;
  assign s_axi_rresp_o = st.rresp;
  assign irq_o = st.irq_pin;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n);

  // Both halves of a write, then the answer on the next edge.
  sequence wr_pair_s;
    st.aw_held && st.w_held && !st.bvalid;
  endsequence
  sequence wr_answer_s;
    ##1 st.bvalid;
  endsequence

  wr_answer_a: assert property (wr_pair_s |-> wr_answer_s)
    else $error("write answer missing");
  // Live fields must follow their inputs with exactly one cycle of lag.
  rate_track_a: assert property (##1
    st.status[15:14] == $past(live_i.resolved_rate))
    else $error("rate field stale");
  link_live_a: assert property (##1
    st.status[10] == $past(live_i.link_up))
    else $error("link bit stale");
  page_clear_a: assert property ((s_axi_arvalid_i && st.arready &&
    rd_idx == `PSS_IDX_STATUS && !page_rx_i) |=> !st.page)
    else $error("page bit not cleared");
  enable_rsvd_a: assert property (!st.enable[9] && !st.enable[7])
    else $error("reserved enable bit set");
  evt_set_a: assert property (event_pulse_i[15] |=> st.events[15])
    else $error("event not latched");
  evt_hold_a: assert property ((st.events[0] && !(s_axi_arvalid_i &&
    st.arready && rd_idx == `PSS_IDX_EVENT)) |=> st.events[0])
    else $error("event lost without read");
  irq_gate_a: assert property (##1 (irq_o ^ $past(st.irq_low)) ==
    $past(|(st.events & st.enable)))
    else $error("interrupt level wrong");
  pol_default_a: assert property ((st.irq_low && !irq_active) |=> irq_o)
    else $error("idle pin not high in low mode");

endmodule // pss_bank

// [design/pss_regs.svh]
// Register indexes, field positions and reset values for the status bank.
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH
// Register indexes; the byte address is four times the index.
`define PSS_IDX_STATUS 6'h11
`define PSS_IDX_ENABLE 6'h12
`define PSS_IDX_EVENT 6'h13
`define PSS_IDX_CONFIG 6'h14
// Status summary field positions.
`define PSS_STS_RATE_HI 15
`define PSS_STS_RATE_LO 14
`define PSS_STS_DUPLEX 13
`define PSS_STS_PAGE 12
`define PSS_STS_RESOLVED 11
`define PSS_STS_LINK 10
`define PSS_STS_X34 9
`define PSS_STS_X12 8
`define PSS_STS_GIGMASK 7
`define PSS_STS_DORMANT 6
`define PSS_STS_POL_HI 5
`define PSS_STS_POL_LO 2
`define PSS_STS_POL10 1
`define PSS_STS_JABBER 0
// Reset images of the registers.
`define PSS_STS_RESET 16'h0002
`define PSS_EN_RESET 16'h0000
`define PSS_EVT_RESET 16'h0000
// Writable bits of the enable register; bits 9 and 7 are reserved.
`define PSS_EN_WMASK 16'hfd7f
// Interrupt polarity bit of the configuration register; one means low.
`define PSS_CFG_POL 13
`define PSS_CFG_POL_RESET 1'h1
// Bus answer codes.
`define PSS_RESP_OKAY 2'h0
`define PSS_RESP_SLVERR 2'h2
`endif

// [design/pss_pkg.sv]
// Types shared by the status and interrupt-enable register bank.
package pss_pkg;
  // Live status fed in by the link and negotiation engines.
  typedef struct packed {
    logic [1:0] resolved_rate;
    logic full_duplex;
    logic neg_resolved;
    logic link_up;
    logic crossover_pairs_34;
    logic crossover_pairs_12;
    logic gigabit_mask_active;
    logic dormant;
    logic [3:0] channel_polarity_reversed;
    logic pol10_correct;
    logic jabber;
  } pss_live_t;

  // Whole state of the bank, registered as one word.
  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] status;
    logic page;
    logic [15:0] enable;
    logic [15:0] events;
    logic irq_low;
    logic irq_pin;
  } pss_state_t;
endpackage

// [testbench/pss_host_model.sv]
// Management host model that drives the AXI4-Lite register bus.
`timescale 1ns/100ps
module pss_host_model
(
  input wire logic clk_i,
  output logic [7:0] aw_addr_o,
  output logic aw_valid_o,
  input wire logic aw_ready_i,
  output logic [31:0] w_data_o,
  output logic w_valid_o,
  input wire logic w_ready_i,
  output logic b_ready_o,
  input wire logic b_valid_i,
  input wire logic [1:0] b_resp_i,
  output logic [7:0] ar_addr_o,
  output logic ar_valid_o,
  input wire logic ar_ready_i,
  input wire logic r_valid_i,
  input wire logic [31:0] r_data_i,
  input wire logic [1:0] r_resp_i,
  output logic r_ready_o
);
  logic aw_ok; // Address half of the write was taken.
  logic w_ok; // Data half of the write was taken.

  // The bus is idle at time zero so the bank sees no stray request.
  initial
  begin
    aw_valid_o = 1'b0;
    w_valid_o = 1'b0;
    b_ready_o = 1'b0;
    ar_valid_o = 1'b0;
    aw_addr_o = 8'h00;
    w_data_o = 32'h0;
    ar_addr_o = 8'h00;
    r_ready_o = 1'b0;
  end

  // One write; each half is held until its own ready edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk_i);
    aw_addr_o <= a;
    w_data_o <= d;
    aw_valid_o <= 1'b1;
    w_valid_o <= 1'b1;
    b_ready_o <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk_i);
      aw_ok = aw_ok | aw_ready_i;
      w_ok = w_ok | w_ready_i;
      aw_valid_o <= !aw_ok;
      w_valid_o <= !w_ok;
    end
    // The answer may take any number of cycles; the watchdog bounds it.
    do @(posedge clk_i); while (!b_valid_i);
    r = b_resp_i;
    b_ready_o <= 1'b0;
  endtask

  // One read; the address stands until taken, then data is awaited.
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk_i);
    ar_addr_o <= a;
    ar_valid_o <= 1'b1;
    r_ready_o <= 1'b1;
    do @(posedge clk_i); while (!ar_ready_i);
    ar_valid_o <= 1'b0;
    // Read-ready stays up until the edge at which the answer is taken.
    do @(posedge clk_i); while (!r_valid_i);
    d = r_data_i;
    r = r_resp_i;
    r_ready_o <= 1'b0;
  endtask
endmodule // pss_host_model

// [testbench/tb_phy_status_and_irq_enable.sv]
// Self-checking bench for the status and interrupt-enable bank.
`timescale 1ns/100ps
`include "pss_regs.svh"
module tb_phy_status_and_irq_enable;
  import pss_pkg::*;
  logic clk, rst_n, page, irq;
  logic awvalid, awready, wvalid, wready, bready, bvalid;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, x;
  logic [1:0] bresp, rresp, r;
  logic [15:0] ev, e;
  pss_live_t live; // Live levels from the link engines.
  logic [12:0] pat [4] = '{13'h1555, 13'h0aaa, 13'h1fff, 13'h0001};
  int miscompares = 0;
  int cmp_count = 0;

  pss_bank pss_bank_i (.clk_sys_i(clk), .reset_n_i(rst_n),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready),
    .live_i(live), .page_rx_i(page), .event_pulse_i(ev), .irq_o(irq));

  pss_host_model pss_host_model_i (.clk_i(clk), .aw_addr_o(awaddr),
    .aw_valid_o(awvalid), .aw_ready_i(awready), .w_data_o(wdata),
    .w_valid_o(wvalid), .w_ready_i(wready), .b_ready_o(bready),
    .b_valid_i(bvalid), .b_resp_i(bresp), .ar_addr_o(araddr),
    .ar_valid_o(arvalid), .ar_ready_i(arready), .r_valid_i(rvalid),
    .r_data_i(rdata), .r_resp_i(rresp), .r_ready_o(rready));

  // The 250 MHz system clock.
  initial clk = 1'b0;
  always #2 clk = ~clk;

  // Counts a comparison and reports a difference at once.
  task automatic chk(input string n, input logic [31:0] xv,
                     input logic [31:0] s);
    cmp_count++;
    if (s !== xv)
    begin
      $display("MISMATCH %s expected %h seen %h", n, xv, s);
      miscompares++;
    end
  endtask

  // Reads a register and checks both its data and its answer code.
  task automatic rchk(input logic [7:0] a, input logic [31:0] xv,
                      input logic [1:0] xr);
    pss_host_model_i.rd(a, d, r);
    chk($sformatf("data at %h", a), xv, d);
    chk($sformatf("resp at %h", a), {30'h0, xr}, {30'h0, r});
  endtask

  // One-cycle pulses, then time for the latch and the pin to follow.
  task automatic pulse(input logic pg, input logic [15:0] v);
    @(posedge clk);
    page <= pg;
    ev <= v;
    @(posedge clk);
    page <= 1'b0;
    ev <= 16'h0000;
    repeat (3) @(posedge clk);
  endtask

  // Sole place where the run ends.
  task give_verdict;
    if (miscompares == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog: the tests need well under two thousand cycles.
  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    give_verdict();
  end

  // Main sequence of bus calls and expected values.
  initial
  begin
    live = 15'h0002;
    page = 1'b0;
    ev = 16'h0000;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rchk(8'h44, 32'h2, 2'h0);
    rchk(8'h48, 32'h0, 2'h0);
    chk("irq idle", 32'h1, {31'h0, irq});
    rchk(8'h00, 32'h0, `PSS_RESP_SLVERR);
    rchk(8'h50, 32'h2000, 2'h0);
    pss_host_model_i.wr(8'h00, 32'hffff, r);
    chk("unmapped wr resp", {30'h0, `PSS_RESP_SLVERR}, {30'h0, r});
    // Status is read-only, so a write is answered but dropped.
    pss_host_model_i.wr(8'h44, 32'hffff, r);
    chk("status wr resp", 32'h0, {30'h0, r});
    rchk(8'h44, 32'h2, 2'h0);
    // Every rate code with varied flags; a second read keeps jabber.
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      live <= {i[1:0], pat[i]};
      repeat (2) @(posedge clk);
      x = {16'h0, live[14:12], 1'b0, live[11:0]};
      rchk(8'h44, x, 2'h0);
      rchk(8'h44, x, 2'h0);
    end
    pulse(1'b1, 16'h0000);
    rchk(8'h44, x | 32'h1000, 2'h0);
    rchk(8'h44, x, 2'h0);
    // All masks off: events latch but the pin stays quiet.
    pulse(1'b0, 16'hffff);
    chk("irq masked", 32'h1, {31'h0, irq});
    rchk(8'h4c, 32'hfd7f, 2'h0);
    rchk(8'h4c, 32'h0, 2'h0);
    pss_host_model_i.wr(8'h48, 32'hffff, r);
    chk("enable wr resp", 32'h0, {30'h0, r});
    rchk(8'h48, 32'hfd7f, 2'h0);
    // Each event alone; reserved positions never raise the pin.
    for (int b = 0; b < 16; b++)
    begin
      e = 16'h1 << b;
      pulse(1'b0, e);
      chk("irq", {31'h0, ~|(e & 16'hfd7f)}, {31'h0, irq});
      rchk(8'h4c, {16'h0, e & 16'hfd7f}, 2'h0);
      repeat (2) @(posedge clk);
      chk("irq cleared", 32'h1, {31'h0, irq});
    end
    // Active-high pin after the polarity bit is cleared.
    pss_host_model_i.wr(8'h50, 32'h0, r);
    chk("config wr resp", 32'h0, {30'h0, r});
    rchk(8'h50, 32'h0, 2'h0);
    repeat (2) @(posedge clk);
    chk("irq high idle", 32'h0, {31'h0, irq});
    pulse(1'b0, 16'h0400);
    chk("irq high", 32'h1, {31'h0, irq});
    give_verdict();
  end
endmodule // tb_phy_status_and_irq_enable
